// ---- verilog/ldc_config_header.sv ----
// Purpose: configuration header register bank with flags, window bases and decode
// Assumes: rst_b is cold reset, warm_rst_b warm reset; both synchronous, active low
// Notes: read data stand in the cycle after the read strobe only, zero otherwise
//
// Overview of operation
// - flag register bits other than defined ones read as zero
// - interrupt status bit shows live legacy source, ignoring interrupt disable
// - capability list bit is read-only and always one
// - with data error response enabled, set master data error on issue/accept
// - forwarding data-error packets never sets master data error
// - returning target abort for own transaction sets signaled target abort
// - own request target or master aborted sets received abort flags
// - own sync flood sets signaled system error
// - relaying a foreign sync flood leaves signaled system error clear
// - accepted read response or posted request with data error sets detected flag
// - flags clear on write of one; only cold reset zeroes them
// - line size, latency, card info, grant and latency maximum read zero
// - base bit 0 shows space; memory bit 3 prefetchable, bit 2 zero (32-bit base)
// - low size bits hardwired zero so sizing by all ones works
// - memory match on writable base bits, base zero-extended to 64 bits
// - memory window size reported is at least 64 bytes
// - io size bits from bit 2 zero, 25-bit compare, base 31:26 zero
// - interrupt line is a read-write scratch, warm reset to a set value
// - bridge registers follow the primary bus reset
// - command enables act on primary side; other command bits zero
// - bridge with master enable clear master-aborts secondary requests
// - data error response enable is command bit 6, warm reset
// - sync flood only when flood report enable is set
//
// Implementation choice: the strobed register port.
module ldc_config_header
  import ldc_pkg::*;
#(
  parameter int MEM_SIZE_LOG2 = 12,
  parameter bit MEM_PREFETCH = 1'b0,
  parameter int IO_SIZE_LOG2 = 5,
  parameter bit IS_BRIDGE = 1'b0,
  parameter logic [7:0] CAP_PTR = 8'h40,
  parameter logic [7:0] IRQ_PIN = 8'h01,
  parameter logic [31:0] MEM_BAR_RESET = 32'h0000_0000,
  parameter logic [31:0] IO_BAR_RESET = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic warm_rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire ldc_event_s events,
  input wire logic intx_active,
  input wire ldc_req_s req,
  input wire logic sec_req_valid,
  output logic io_space_en,
  output logic mem_space_en,
  output logic bus_master_en,
  output logic intx_allowed,
  output logic flood_go,
  output logic mem_hit,
  output logic io_hit,
  output logic sec_master_abort
);
  // memory window sizes below 64 bytes are widened, io sizes below 4 bytes
  localparam int MEM_N = (MEM_SIZE_LOG2 < MIN_MEM_LOG2) ? MIN_MEM_LOG2 : MEM_SIZE_LOG2;
  localparam int IO_N = (IO_SIZE_LOG2 < IO_SIZE_LO) ? IO_SIZE_LO : IO_SIZE_LOG2;
  localparam logic [31:0] MEM_WMASK = ~((32'h1 << MEM_N) - 32'h1);
  localparam logic [31:0] IO_WMASK = ~((32'h1 << IO_N) - 32'h1);
  localparam logic [31:0] MEM_RO_BITS = {28'h0, MEM_PREFETCH, 3'h0};
  localparam logic [31:0] IO_RO_BITS = 32'h0000_0001;

  logic [15:0] cmd;
  logic [15:0] flags;
  logic [31:0] mem_bar;
  logic [31:0] io_bar;
  logic [7:0] irq_line;
  logic [15:0] next_cmd;
  logic [15:0] next_flags;
  logic [31:0] next_rdata;

  // register port decode
  wire wr_cmd = wr && (addr == OFS_CMD_STAT);
  wire wr_mem_bar = wr && (addr == OFS_BAR_MEM);
  wire wr_io_bar = wr && (addr == OFS_BAR_IO);
  wire wr_irq = wr && (addr == OFS_IRQ);

  // flag set terms
  wire derr_rsp_en = cmd[CMD_DERR_RSP];
  wire set_mde = derr_rsp_en && (events.issued_posted_derr || events.accepted_resp_derr);
  wire set_ded = events.accepted_rdrsp_derr || events.accepted_post_derr;
  wire flood_now = events.sync_flood_req && cmd[CMD_FLOOD_EN];
  wire [15:0] flag_set = (16'h1 << ST_MDE) & {16{set_mde}}
    | (16'h1 << ST_STA) & {16{events.tgt_abort_returned}}
    | (16'h1 << ST_RTA) & {16{events.rcv_tgt_abort}}
    | (16'h1 << ST_RMA) & {16{events.rcv_mstr_abort}}
    | (16'h1 << ST_SSE) & {16{flood_now}}
    | (16'h1 << ST_DED) & {16{set_ded}};
  wire [15:0] flag_clr = wr_cmd ? (wdata[31:LANE_FLAGS] & ST_CLR_MASK) : 16'h0000;

  // next command and flags: writable command bits only, set beats clear
  always_comb begin
    next_cmd = wr_cmd ? (wdata[15:0] & CMD_WMASK) : cmd;
    next_flags = ((flags & ~flag_clr) | flag_set) & ST_CLR_MASK;
  end

  // live flag view: interrupt state and capability bit added on read
  wire [15:0] flags_view = flags | ((16'h1 << ST_CAP))
    | ((16'h1 << ST_INT) & {16{intx_active}});

  // window matching on writable base bits
  wire [31:0] io_addr25 = {7'h00, req.io_addr[IO_ADDR_BITS-1:0]};
  wire mem_match = req.mem_valid && cmd[CMD_MEM_EN] && (req.mem_addr[63:32] == ZERO32)
    && ((req.mem_addr[31:0] & MEM_WMASK) == (mem_bar & MEM_WMASK));
  wire io_match = req.io_valid && cmd[CMD_IO_EN] && (io_bar[31:IO_ZERO_LO] == 6'h00)
    && ((io_addr25 & IO_WMASK) == (io_bar & IO_WMASK));

  // read mux, unmapped and unimplemented offsets read zero
  wire bar_gap = (addr > OFS_BAR_IO) && (addr <= OFS_BAR_LAST);
  always_comb begin
    next_rdata = ZERO32;
    if (rd) begin
      case (addr)
        OFS_CMD_STAT: next_rdata = {flags_view, cmd};
        OFS_LINE_LAT: next_rdata = ZERO32;
        OFS_BAR_MEM: next_rdata = (mem_bar & MEM_WMASK) | MEM_RO_BITS;
        OFS_BAR_IO: next_rdata = (io_bar & IO_WMASK) | IO_RO_BITS;
        OFS_CARD_INFO: next_rdata = ZERO32;
        OFS_CAP_HEAD: next_rdata = {24'h000000, CAP_PTR};
        OFS_IRQ: next_rdata = {16'h0000, IRQ_PIN, irq_line};
        default: next_rdata = ZERO32;
      endcase
      if (bar_gap) begin
        next_rdata = ZERO32;
      end
    end
  end

  // cold-only flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags <= ST_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // warm-reset registers; for a bridge these reset lines are the primary bus resets
  always_ff @(posedge clk) begin
    if (!rst_b || !warm_rst_b) begin
      cmd <= CMD_RESET;
      mem_bar <= MEM_BAR_RESET;
      io_bar <= IO_BAR_RESET;
      irq_line <= IRQ_LINE_RESET;
    end else begin
      cmd <= next_cmd;
      if (wr_mem_bar) mem_bar <= wdata & MEM_WMASK;
      if (wr_io_bar) io_bar <= wdata & IO_WMASK;
      if (wr_irq) irq_line <= wdata[7:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!rst_b || !warm_rst_b) begin
      rdata <= ZERO32;
      flood_go <= 1'b0;
      mem_hit <= 1'b0;
      io_hit <= 1'b0;
      sec_master_abort <= 1'b0;
      io_space_en <= 1'b0;
      mem_space_en <= 1'b0;
      bus_master_en <= 1'b0;
      intx_allowed <= 1'b0;
    end else begin
      rdata <= next_rdata;
      flood_go <= flood_now;
      mem_hit <= mem_match;
      io_hit <= io_match;
      sec_master_abort <= IS_BRIDGE && sec_req_valid && !cmd[CMD_BM_EN];
      io_space_en <= next_cmd[CMD_IO_EN];
      mem_space_en <= next_cmd[CMD_MEM_EN];
      bus_master_en <= next_cmd[CMD_BM_EN];
      intx_allowed <= !next_cmd[CMD_INT_DIS];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !warm_rst_b);

  sequence s_read_cmd;
    rd && addr == OFS_CMD_STAT;
  endsequence

  a_flag_zero_bits: assert property (s_read_cmd |=> (rdata[31:16] & 16'h06E7) == 16'h0000)
    else $error("undefined flag bits read nonzero");
  a_int_live: assert property (s_read_cmd |=> rdata[LANE_FLAGS+ST_INT] == $past(intx_active))
    else $error("interrupt status not live");
  a_cap_bit_one: assert property (s_read_cmd |=> rdata[LANE_FLAGS+ST_CAP])
    else $error("capability bit not one");
  a_mde_gated: assert property (
    (events.issued_posted_derr || events.accepted_resp_derr) && !cmd[CMD_DERR_RSP]
    && !flags[ST_MDE] |=> !flags[ST_MDE])
    else $error("master data error set while response disabled");
  a_mde_fwd_only: assert property (
    events.forwarded_derr && !events.issued_posted_derr && !events.accepted_resp_derr
    && !flags[ST_MDE] |=> !flags[ST_MDE])
    else $error("forwarding set master data error");
  a_sta_set: assert property (events.tgt_abort_returned |=> flags[ST_STA])
    else $error("signaled target abort not set");
  a_rx_abort_set: assert property (
    events.rcv_tgt_abort || events.rcv_mstr_abort
    |=> (flags[ST_RTA] || !$past(events.rcv_tgt_abort))
    && (flags[ST_RMA] || !$past(events.rcv_mstr_abort)))
    else $error("received abort flag not set");
  a_sse_own: assert property (flood_now |=> flags[ST_SSE] ##0 flood_go)
    else $error("own flood did not set system error");
  a_sse_relay: assert property (
    events.relayed_flood && !events.sync_flood_req && !flags[ST_SSE] |=> !flags[ST_SSE])
    else $error("relayed flood set system error");
  a_ded_done: assert property (
    events.accepted_done_derr && !set_ded && !flags[ST_DED] |=> !flags[ST_DED])
    else $error("target-done set data error detected");
  a_w1c_clear: assert property (
    wr_cmd && wdata[LANE_FLAGS+ST_RMA] && !events.rcv_mstr_abort |=> !flags[ST_RMA])
    else $error("write one did not clear flag");
  a_set_wins: assert property (
    wr_cmd && wdata[LANE_FLAGS+ST_STA] && events.tgt_abort_returned |=> flags[ST_STA])
    else $error("clear beat a same-cycle set");
  a_unused_zero: assert property (
    rd && (addr == OFS_LINE_LAT || addr == OFS_CARD_INFO) |=> rdata == ZERO32)
    else $error("unimplemented register read nonzero");
  a_bar_low_bits: assert property (
    rd && addr == OFS_BAR_IO |=> rdata[1:0] == 2'b01 && rdata[IO_N-1:IO_SIZE_LO] == '0)
    else $error("io base low bits wrong");
  a_mem_size_min: assert property (rd && addr == OFS_BAR_MEM |=> rdata[5:0] == 6'(MEM_RO_BITS))
    else $error("memory window under 64 bytes");
  a_mem_high_miss: assert property (
    req.mem_valid && req.mem_addr[63:32] != ZERO32 |=> !mem_hit)
    else $error("memory hit above 4 GB with 32-bit base");
  a_io_high_base: assert property (io_bar[31:IO_ZERO_LO] != 6'h00 |=> !io_hit)
    else $error("io hit with nonzero high base bits");
  a_cmd_unused: assert property (s_read_cmd |=> (rdata[15:0] & ~CMD_WMASK) == 16'h0000)
    else $error("unlisted command bits nonzero");
  a_bridge_abort: assert property (
    sec_req_valid && !cmd[CMD_BM_EN] && IS_BRIDGE |=> sec_master_abort)
    else $error("bridge did not master-abort");
  a_flood_gate: assert property (!cmd[CMD_FLOOD_EN] |=> !flood_go)
    else $error("flood while report disabled");
endmodule : ldc_config_header

// ---- verilog/ldc_pkg.sv ----
// Purpose: shared constants and carriers for the link device configuration header
// Assumes: byte offsets are configuration-space offsets; access is by aligned dword
// Notes: 16- and 8-bit registers sit in their byte lanes of the dword that holds them
package ldc_pkg;
  // dword-aligned byte addresses seen on the register port
  localparam logic [7:0] OFS_CMD_STAT = 8'h04; // command low half, flags high half
  localparam logic [7:0] OFS_LINE_LAT = 8'h0C; // line size and latency count (unused)
  localparam logic [7:0] OFS_BAR_MEM = 8'h10;
  localparam logic [7:0] OFS_BAR_IO = 8'h14;
  localparam logic [7:0] OFS_BAR_LAST = 8'h24;
  localparam logic [7:0] OFS_CARD_INFO = 8'h28;
  localparam logic [7:0] OFS_CAP_HEAD = 8'h34;
  localparam logic [7:0] OFS_IRQ = 8'h3C; // line, pin, grant minimum, latency maximum
  // printed byte offsets of the sub-dword registers, kept for lane placement
  localparam logic [7:0] OFS_FLAGS_BYTE = 8'h06;
  localparam logic [7:0] OFS_LAT_BYTE = 8'h0D;
  localparam logic [7:0] OFS_PIN_BYTE = 8'h3D;
  localparam logic [7:0] OFS_GNT_BYTE = 8'h3E;
  localparam logic [7:0] OFS_MAXLAT_BYTE = 8'h3F;
  localparam int LANE_FLAGS = 16; // flags sit in bits 31:16 of their dword
  localparam int LANE_PIN = 8;
  // command bits
  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_BM_EN = 2;
  localparam int CMD_DERR_RSP = 6;
  localparam int CMD_FLOOD_EN = 8;
  localparam int CMD_INT_DIS = 10;
  localparam logic [15:0] CMD_WMASK = 16'h0547;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // flag bits
  localparam int ST_INT = 3;
  localparam int ST_CAP = 4;
  localparam int ST_MDE = 8;
  localparam int ST_STA = 11;
  localparam int ST_RTA = 12;
  localparam int ST_RMA = 13;
  localparam int ST_SSE = 14;
  localparam int ST_DED = 15;
  localparam logic [15:0] ST_CLR_MASK = 16'hF900;
  localparam logic [15:0] ST_RESET = 16'h0000;
  // window base fields
  localparam int BAR_SPACE = 0;
  localparam int BAR_64B = 2;
  localparam int BAR_PREF = 3;
  localparam int MEM_SIZE_LO = 4;
  localparam int IO_SIZE_LO = 2;
  localparam int IO_ADDR_BITS = 25;
  localparam int IO_ZERO_LO = 26;
  localparam int MIN_MEM_LOG2 = 6; // 64 bytes
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [7:0] IRQ_LINE_RESET = 8'h00;

  // one-cycle event pulses from the transaction logic
  typedef struct packed {
    logic issued_posted_derr;  // this device issued a posted request marked data error
    logic accepted_resp_derr;  // accepted any response marked data error
    logic accepted_rdrsp_derr; // accepted read response marked data error
    logic accepted_post_derr;  // accepted posted request marked data error
    logic accepted_done_derr;  // accepted target-done marked data error
    logic forwarded_derr;      // only forwarded a data-error packet
    logic tgt_abort_returned;  // returned target abort for own transaction
    logic rcv_tgt_abort;       // own request completed with target abort
    logic rcv_mstr_abort;      // own request completed with master abort
    logic sync_flood_req;      // own error wants a sync flood
    logic relayed_flood;       // flood seen from elsewhere, only relayed
  } ldc_event_s;

  // incoming request addresses for window matching
  typedef struct packed {
    logic mem_valid;
    logic [63:0] mem_addr;
    logic io_valid;
    logic [31:0] io_addr;
  } ldc_req_s;
endpackage : ldc_pkg

// ---- tb/ldc_link_peer.sv ----
// Purpose: link peer model that sends one-cycle events and requests
// Assumes: the bench asks for a burst by holding fire high for one cycle
// Notes: all outputs change on a rising edge; pulses last one cycle
module ldc_link_peer
  import ldc_pkg::*;
(
  input wire logic clk,
  input wire logic fire,
  input wire logic [10:0] pat,
  input wire logic sec_go,
  input wire logic intx_lvl,
  output ldc_event_s events,
  output logic sec_req_valid,
  output logic intx_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // event and secondary pulses fall back to zero after one cycle
  always_ff @(posedge clk) begin
    events <= fire ? ldc_event_s'(pat) : ldc_event_s'(11'h000);
    sec_req_valid <= fire & sec_go;
    intx_active <= intx_lvl;
  end
endmodule : ldc_link_peer

// ---- tb/link_device_config_header_tb.sv ----
// Purpose: self-checking bench for the configuration header
// Assumes: bridge build, 64-byte memory window, 32-byte io window
// Notes: register access through one-cycle strobes, read data one cycle later
module link_device_config_header_tb
  import ldc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic warm_rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic [10:0] pat = 11'h000;
  logic sec_go = 1'b0;
  logic intx_lvl = 1'b0;
  ldc_req_s req = '0;
  logic [31:0] rdata;
  ldc_event_s events;
  logic intx_active, sec_req_valid, io_space_en, mem_space_en, bus_master_en;
  logic intx_allowed, flood_go, mem_hit, io_hit, sec_master_abort;
  logic fgo, sma;
  int err_total = 0;
  int compares = 0;
  // per event bit: flag bits looked at and their expected value
  logic [15:0] msk [0:10] = '{16'h4000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
    16'h8100, 16'h8000, 16'h8000, 16'h8000, 16'h0100, 16'h0100};
  logic [15:0] expv [0:10] = '{16'h0000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
    16'h0000, 16'h0000, 16'h8000, 16'h8000, 16'h0100, 16'h0100};
  logic [7:0] zad [0:6] = '{8'h0C, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h80};

  always #20 clk = ~clk;

  ldc_config_header #(.MEM_SIZE_LOG2(4), .MEM_PREFETCH(1'b1), .IO_SIZE_LOG2(5),
    .IS_BRIDGE(1'b1), .IRQ_PIN(8'h01)) ldc_config_header_inst (
    .clk(clk), .rst_b(rst_b), .warm_rst_b(warm_rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .events(events), .intx_active(intx_active),
    .req(req), .sec_req_valid(sec_req_valid), .io_space_en(io_space_en),
    .mem_space_en(mem_space_en), .bus_master_en(bus_master_en),
    .intx_allowed(intx_allowed), .flood_go(flood_go), .mem_hit(mem_hit),
    .io_hit(io_hit), .sec_master_abort(sec_master_abort));

  ldc_link_peer ldc_link_peer_inst (.clk(clk), .fire(fire), .pat(pat),
    .sec_go(sec_go), .intx_lvl(intx_lvl), .events(events),
    .sec_req_valid(sec_req_valid), .intx_active(intx_active));

  // verdict and end of run
  task automatic finish_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // single comparison of a 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read, keep the bits of m, compare with e
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rd_chk

  // one peer burst; grabs the registered answers one cycle after it lands
  task automatic pulse(input logic [10:0] p, input logic s);
    @(posedge clk);
    fire <= 1'b1;
    pat <= p;
    sec_go <= s;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
    fgo = flood_go;
    sma = sec_master_abort;
  endtask : pulse

  task automatic hit(input logic [63:0] ma, input logic [31:0] ia, input logic [1:0] e);
    @(posedge clk);
    req <= '{1'b1, ma, 1'b1, ia};
    @(posedge clk);
    req.mem_valid <= 1'b0;
    req.io_valid <= 1'b0;
    #1;
    chk({30'h0, mem_hit, io_hit}, {30'h0, e});
  endtask : hit

  task automatic do_reset(input logic cold, input int n);
    @(posedge clk);
    rst_b <= ~cold;
    warm_rst_b <= 1'b0;
    repeat (n) @(posedge clk);
    rst_b <= 1'b1;
    warm_rst_b <= 1'b1;
  endtask : do_reset

  // watchdog against a hang
  initial begin
    #(40 * 20000);
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    do_reset(1'b1, 10);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_FFFF, 32'h0010_0000);
    for (int i = 0; i < 7; i++) rd_chk(zad[i], 32'hFFFF_FFFF, 32'h0);
    rd_chk(OFS_CAP_HEAD, 32'hFFFF_FFFF, 32'h0000_0040);
    wr_reg(OFS_CMD_STAT, 32'hFFFF_FFFF);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_FFFF, 32'h0010_0547);
    chk({28'h0, io_space_en, mem_space_en, bus_master_en, intx_allowed}, 32'hE);
    @(posedge clk);
    intx_lvl <= 1'b1;
    rd_chk(OFS_CMD_STAT, 32'h0008_0000, 32'h0008_0000);
    @(posedge clk);
    intx_lvl <= 1'b0;
    wr_reg(OFS_CMD_STAT, 32'h0000_0000);
    wr_reg(OFS_BAR_MEM, 32'hFFFF_FFFF);
    rd_chk(OFS_BAR_MEM, 32'hFFFF_FFFF, 32'hFFFF_FFC8);
    wr_reg(OFS_BAR_IO, 32'hFFFF_FFFF);
    rd_chk(OFS_BAR_IO, 32'hFFFF_FFFF, 32'hFFFF_FFE1);
    wr_reg(OFS_BAR_MEM, 32'h1234_5680);
    wr_reg(OFS_BAR_IO, 32'h0000_1040);
    wr_reg(OFS_CMD_STAT, 32'h0000_0147);
    hit(64'h0000_0000_1234_56BF, 32'h0000_105F, 2'b11);
    chk({28'h0, io_space_en, mem_space_en, bus_master_en, intx_allowed}, 32'hF);
    hit(64'h0000_0001_1234_5680, 32'hFE00_104F, 2'b01);
    hit(64'h0000_0000_1234_56C0, 32'h0000_1060, 2'b00);
    wr_reg(OFS_BAR_IO, 32'h0200_1040);
    hit(64'h0, 32'h0000_1040, 2'b00);
    wr_reg(OFS_BAR_IO, 32'h0400_1040);
    hit(64'h0, 32'h0000_1040, 2'b00);
    // each event alone, then cleared by writing ones
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i, 1'b0);
      chk({31'h0, fgo}, 32'(i == 1));
      rd_chk(OFS_CMD_STAT, {msk[i], 16'h0}, {expv[i], 16'h0});
      wr_reg(OFS_CMD_STAT, 32'hFFFF_0147);
      rd_chk(OFS_CMD_STAT, 32'hFFFF_FFFF, 32'h0010_0147);
    end
    wr_reg(OFS_CMD_STAT, 32'h0000_0007);
    pulse(11'h400, 1'b0);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_0000, 32'h0010_0000);
    pulse(11'h002, 1'b0);
    chk({31'h0, fgo}, 32'h0);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_0000, 32'h0010_0000);
    chk({31'h0, sma}, 32'h0);
    wr_reg(OFS_CMD_STAT, 32'h0000_0003);
    pulse(11'h000, 1'b1);
    chk({31'h0, sma}, 32'h1);
    wr_reg(OFS_IRQ, 32'hFFFF_FF5A);
    rd_chk(OFS_IRQ, 32'hFFFF_FFFF, 32'h0000_015A);
    pulse(11'h004, 1'b0);
    do_reset(1'b0, 2);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_FFFF, 32'h2010_0000);
    rd_chk(OFS_IRQ, 32'hFFFF_FFFF, 32'h0000_0100);
    do_reset(1'b1, 2);
    rd_chk(OFS_CMD_STAT, 32'hFFFF_FFFF, 32'h0010_0000);
    finish_test();
  end
endmodule : link_device_config_header_tb
